//--- logic/qfw_pkg.sv
// Opcodes, status layout and timing for the flash write-control block
package qfw_pkg;
	localparam logic [7:0] OP_WR_EN    = 8'h06;
	localparam logic [7:0] OP_WR_DIS   = 8'h04;
	localparam logic [7:0] OP_VOL_EN   = 8'h50;
	localparam logic [7:0] OP_SR1_WR   = 8'h01;
	localparam logic [7:0] OP_SR2_WR   = 8'h31;
	localparam logic [7:0] OP_SR1_RD   = 8'h05;
	localparam logic [7:0] OP_SR2_RD   = 8'h35;
	localparam logic [7:0] OP_ID_RD0   = 8'h9e;
	localparam logic [7:0] OP_ID_RD1   = 8'h9f;
	localparam logic [7:0] OP_WIDE_ON  = 8'hb7;
	localparam logic [7:0] OP_WIDE_OFF = 8'he9;
	localparam logic [7:0] OP_PD_IN    = 8'hb9;
	localparam logic [7:0] OP_PD_OUT   = 8'hab;
	localparam logic [7:0] OP_PP3A     = 8'h02;
	localparam logic [7:0] OP_PP3B     = 8'h32;
	localparam logic [7:0] OP_PP3C     = 8'hc2;
	localparam logic [7:0] OP_PP4A     = 8'h12;
	localparam logic [7:0] OP_PP4B     = 8'h34;
	localparam logic [7:0] OP_PP4C     = 8'h3e;
	localparam logic [7:0] OP_SE3      = 8'h20;
	localparam logic [7:0] OP_BE32     = 8'h52;
	localparam logic [7:0] OP_BE64     = 8'hd8;
	localparam logic [7:0] OP_SE4      = 8'h21;
	localparam logic [7:0] OP_BE32_4   = 8'h5c;
	localparam logic [7:0] OP_BE64_4   = 8'hdc;
	localparam logic [7:0] OP_CE_A     = 8'hc7;
	localparam logic [7:0] OP_CE_B     = 8'h60;
	localparam logic [7:0] OP_OTP_RD   = 8'h48;
	localparam logic [7:0] OP_OTP_PGM  = 8'h42;
	localparam logic [7:0] OP_OTP_ERS  = 8'h44;
	localparam logic [7:0] OP_LOCK     = 8'h36;
	localparam logic [7:0] OP_UNLOCK   = 8'h39;
	localparam logic [7:0] OP_LOCK_RD  = 8'h3d;
	localparam logic [7:0] OP_GLOCK    = 8'h7e;
	localparam logic [7:0] OP_GUNLOCK  = 8'h98;
	localparam logic [7:0] OP_UPPER_WR = 8'hc5;
	localparam logic [7:0] OP_CFG_NV   = 8'hb1;
	localparam logic [7:0] OP_CFG_VOL  = 8'h81;
	localparam int SB_BUSY  = 0;
	localparam int SB_LATCH = 1;
	localparam int SB_SIZE0 = 2;
	localparam int SB_LOCK0 = 7;
	localparam int SB_WIDE  = 8;
	localparam int SB_LOCK1 = 9;
	localparam int MB_PD    = 16;
	localparam int MB_GLOCK = 17;
	localparam logic [15:0] SR_WR_MASK = 16'h02fc;
	localparam logic [15:0] SR_RST     = 16'h0000;
	localparam logic [9:0] NIB_OP   = 10'h002;
	localparam logic [9:0] NIB_A3   = 10'h006;
	localparam logic [9:0] NIB_A4   = 10'h008;
	localparam logic [9:0] NIB_BYTE = 10'h002;
	localparam logic [9:0] NIB_MAXD = 10'h200;
	localparam logic [9:0] DUM_OTP  = 10'h006;
	localparam logic [9:0] DUM_LOCK = 10'h008;
	localparam logic [9:0] CNT_SAT  = 10'h3ff;
	localparam int CLK_MHZ = 250;
	localparam int STATUS_WRITE_TIME_US = 5000;
	localparam int SW_CYCLES = STATUS_WRITE_TIME_US * CLK_MHZ;
	// Arbitrary identity values, not those of any real part
	localparam logic [7:0]  MFR_CODE = 8'h5a;
	localparam logic [23:0] DEV_CODE = 24'h3ca501;
	typedef enum logic [1:0] {
		QFW_IDLE = 2'b01,
		QFW_BUSY = 2'b10
	} qfw_state_t;
	typedef struct packed {
		logic [7:0] op;
		logic [9:0] cnt;
		logic [7:0] data;
	} qfw_frame_t;
endpackage

//--- logic/qfw_write_ctrl.sv
// Four-wire flash command interpreter: write latch, status writes, modes
//
// Overview of operation
// - Four-byte page programs 12h/34h/3Eh: 8 address nibbles, 1-256 bytes
// - Erases 20h/52h/D8h, fixed 21h/5Ch/DCh, chip erase C7h/60h, no data
// - OTP read 48h with 6 dummies, program 42h, erase 44h, 3/4 address
// - Lock read 3Dh 8 dummies; 7Eh/98h global lock and unlock
// - Power-down B9h and release ABh are opcode-only frames
// - ID read 9Eh/9Fh returns maker byte then 24-bit device code
// - B7h sets the wide address flag; addresses become 32-bit
// - E9h clears the wide address flag; addresses back to 24-bit
// - Opcode 06h sets the write permit latch
// - Program, erase, non-volatile register writes refused unless permit latch set first
// - Opcode 04h clears the write permit latch
// - Permit latch cleared at reset and when any timed write cycle completes
// - 50h arms only the next frame; anything else disarms it
// - 50h leaves the permit latch alone; status write goes volatile
// - Status write executes only if select rises after eighth data bit
// - Valid status write runs timed cycle with busy flag, then clears latch
// - Status reads keep working during the timed cycle
// - Status write updates the five protect size bits
// - Lock bit zero with write-protect pin forms hardware protection
// - Under hardware protection status writes are ignored
// - 05h returns status bits 7..0, 35h bits 15..8, any time outside power-down
`timescale 1ns/1ps
module qfw_write_ctrl
	import qfw_pkg::*;
#(
	parameter int SW_CYC = SW_CYCLES
) (
	input  wire logic       clk,      // Core clock
	input  wire logic       nrst,     // Async reset, active low
	input  wire logic       ce,       // Core clock enable
	input  wire logic       sclk,     // Link serial clock
	input  wire logic       cs_n,     // Chip select, active low
	input  wire logic [3:0] io_in,    // Data lines in
	output logic      [3:0] io_out,   // Data lines out
	output logic      [3:0] io_oe,    // Data line drive enables
	input  wire logic       wp_n,     // Write-protect pin, active low
	output logic     [15:0] sr_q,     // Status register view
	output logic            pd_q,     // Deep power-down state
	output logic            glock_q   // Global sector lock state
);

	function automatic logic [9:0] addr_nib(
		input logic [7:0] op,
		input logic       wide
	);
		case (op)
			OP_PP4A, OP_PP4B, OP_PP4C,
			OP_SE4, OP_BE32_4, OP_BE64_4: addr_nib = NIB_A4;
			default: addr_nib = wide ? NIB_A4 : NIB_A3;
		endcase
	endfunction

	function automatic logic [15:0] sr_merge(
		input logic [15:0] old,
		input logic [7:0]  val,
		input logic        upper
	);
		logic [15:0] m;
		logic [15:0] v;
		m = SR_WR_MASK & (upper ? 16'hff00 : 16'h00ff);
		v = upper ? {val, 8'h00} : {8'h00, val};
		sr_merge = (old & ~m) | (v & m);
	endfunction

	// ---- Link domain ----
	qfw_frame_t  lk_q;
	logic        started_q;
	logic [17:0] mir_l1_q;
	logic [17:0] mir_l2_q;

	// Cleared by select itself, so a stopped clock cannot leave a frame open
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			started_q <= 1'b0;
		end else begin
			started_q <= 1'b1;
		end
	end

	wire [9:0] lk_cnt_inc = (lk_q.cnt == CNT_SAT) ? CNT_SAT
		: lk_q.cnt + 10'h001;

	always_ff @(posedge sclk) begin
		lk_q.cnt  <= started_q ? lk_cnt_inc : 10'h001;
		lk_q.data <= {lk_q.data[3:0], io_in};
		if (!started_q) begin
			lk_q.op <= {4'h0, io_in};
		end else if (lk_q.cnt == 10'h001) begin
			lk_q.op <= {lk_q.op[3:0], io_in};
		end
	end

	// Status mirror into the link domain; only the second stage is read
	always_ff @(posedge sclk) begin
		mir_l1_q <= {glock_q, pd_q, sr_q};
		mir_l2_q <= mir_l1_q;
	end

	wire [7:0] l_op  = lk_q.op;
	wire [9:0] l_an  = addr_nib(l_op, mir_l2_q[SB_WIDE]);
	wire l_is_sr  = (l_op == OP_SR1_RD) || (l_op == OP_SR2_RD);
	wire l_is_id  = (l_op == OP_ID_RD0) || (l_op == OP_ID_RD1);
	wire l_is_otp = (l_op == OP_OTP_RD);
	wire l_is_lk  = (l_op == OP_LOCK_RD);
	wire [9:0] l_lead = l_is_otp ? NIB_OP + l_an + DUM_OTP
		: l_is_lk ? NIB_OP + l_an + DUM_LOCK : NIB_OP;
	wire [9:0] l_idx = lk_q.cnt - l_lead;
	wire l_busy = mir_l2_q[SB_BUSY];
	wire l_past = started_q && (lk_q.cnt >= l_lead);
	// Array-side reads are refused while a timed cycle runs
	wire l_rd = l_past && !mir_l2_q[MB_PD] && (l_is_sr
		|| (!l_busy && (l_is_id || l_is_otp
		|| (l_is_lk && l_idx < NIB_BYTE))));
	wire [7:0] l_id_byte = (l_idx[9:1] == 9'd0) ? MFR_CODE
		: (l_idx[9:1] == 9'd1) ? DEV_CODE[23:16]
		: (l_idx[9:1] == 9'd2) ? DEV_CODE[15:8] : DEV_CODE[7:0];
	wire [7:0] l_byte = (l_op == OP_SR1_RD) ? mir_l2_q[7:0]
		: (l_op == OP_SR2_RD) ? mir_l2_q[15:8]
		: l_is_id ? l_id_byte
		: l_is_lk ? {8{mir_l2_q[MB_GLOCK]}} : 8'hff;
	wire [3:0] l_nib = l_idx[0] ? l_byte[3:0] : l_byte[7:4];

	// Launched on the falling edge so the host samples on the rising one
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			io_oe  <= 4'h0;
			io_out <= 4'h0;
		end else begin
			io_oe  <= {4{l_rd}};
			io_out <= l_rd ? l_nib : 4'h0;
		end
	end

	// ---- Core domain ----
	logic rst_s1_q;
	logic rst_n_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	logic cs_s1_q;
	logic cs_s2_q;
	logic cs_s3_q;
	logic wp_s1_q;
	logic wp_s2_q;

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_s3_q <= 1'b1;
			wp_s1_q <= 1'b1;
			wp_s2_q <= 1'b1;
		end else if (ce) begin
			cs_s1_q <= cs_n;
			cs_s2_q <= cs_s1_q;
			cs_s3_q <= cs_s2_q;
			wp_s1_q <= wp_n;
			wp_s2_q <= wp_s1_q;
		end
	end

	// Frame fields are quiet once select is high, so they are read directly
	wire       fe  = cs_s2_q && !cs_s3_q;
	wire [7:0] op  = lk_q.op;
	wire [9:0] n   = lk_q.cnt;
	wire [7:0] dat = lk_q.data;

	qfw_state_t  st_q;
	qfw_state_t  st_d;
	logic [31:0] tmr_q;
	logic        wel_q;
	logic        wide_q;
	logic        arm_q;
	logic        srw_pend_q;
	logic [15:0] prot_q;
	logic [15:0] nv_q;
	logic [15:0] pend_q;

	wire [9:0] an  = addr_nib(op, wide_q);
	wire idle      = (st_q == QFW_IDLE);
	wire acc       = fe && idle && !pd_q;
	wire solo      = (n == NIB_OP);
	wire hw_prot   = (prot_q[SB_LOCK0] && !wp_s2_q)
		|| prot_q[SB_LOCK1];

	wire is_prog = (op == OP_PP3A) || (op == OP_PP3B) || (op == OP_PP3C)
		|| (op == OP_PP4A) || (op == OP_PP4B) || (op == OP_PP4C)
		|| (op == OP_OTP_PGM);
	wire prog_ok = (n >= NIB_OP + an + NIB_BYTE)
		&& (n <= NIB_OP + an + NIB_MAXD) && !n[0];
	wire is_er = (op == OP_SE3) || (op == OP_BE32) || (op == OP_BE64)
		|| (op == OP_SE4) || (op == OP_BE32_4) || (op == OP_BE64_4)
		|| (op == OP_OTP_ERS);
	wire er_ok = (n == NIB_OP + an);
	wire is_ce = (op == OP_CE_A) || (op == OP_CE_B);
	wire is_cfg = (op == OP_CFG_NV) || (op == OP_CFG_VOL);
	wire cfg_ok = (n == NIB_OP + an + NIB_BYTE);
	wire up_ok = (op == OP_UPPER_WR) && (n == NIB_OP + NIB_BYTE);
	wire is_srw = (op == OP_SR1_WR) || (op == OP_SR2_WR);
	// Select must rise right after the eighth data bit
	wire srw_ok = is_srw && (n == NIB_OP + NIB_BYTE);
	wire [15:0] sr_new = sr_merge(prot_q, dat, op == OP_SR2_WR);

	// Volatile path: armed by 50h, needs no latch, no timed cycle
	wire vol_wr = acc && arm_q && srw_ok && !hw_prot;
	wire arr_op = (is_prog && prog_ok) || (is_er && er_ok)
		|| (is_ce && solo) || (is_cfg && cfg_ok) || up_ok;
	wire nv_srw = srw_ok && !arm_q && !hw_prot;
	wire start  = acc && wel_q && (arr_op || nv_srw);
	wire done   = (st_q == QFW_BUSY) && (tmr_q == 32'h0);

	always_comb begin
		st_d = st_q;
		case (st_q)
			QFW_IDLE: begin
				if (start) begin
					st_d = QFW_BUSY;
				end
			end
			QFW_BUSY: begin
				if (done) begin
					st_d = QFW_IDLE;
				end
			end
			default: st_d = QFW_IDLE;
		endcase
	end

	wire [31:0] tmr_d = start ? 32'(SW_CYC - 1)
		: (tmr_q != 32'h0) ? tmr_q - 32'h1 : 32'h0;

	// Completion clears the latch; busy blocks 06h so nothing collides
	wire wel_d = done ? 1'b0
		: (acc && solo && op == OP_WR_EN) ? 1'b1
		: (acc && solo && op == OP_WR_DIS) ? 1'b0
		: wel_q;
	wire wide_d = (acc && solo && op == OP_WIDE_ON) ? 1'b1
		: (acc && solo && op == OP_WIDE_OFF) ? 1'b0
		: wide_q;
	wire pd_d = (acc && solo && op == OP_PD_IN) ? 1'b1
		: (fe && idle && solo && op == OP_PD_OUT) ? 1'b0 : pd_q;
	wire glock_d = (acc && solo && op == OP_GLOCK) ? 1'b1
		: (acc && solo && op == OP_GUNLOCK) ? 1'b0 : glock_q;
	// Every frame end re-decides the arm; only a lone 50h keeps it
	wire arm_d = fe ? (acc && solo && op == OP_VOL_EN) : arm_q;
	wire srw_pend_d = start ? nv_srw : (done ? 1'b0 : srw_pend_q);
	wire [15:0] pend_d = (start && nv_srw) ? sr_new : pend_q;
	wire [15:0] prot_d = (done && srw_pend_q) ? pend_q
		: vol_wr ? sr_new : prot_q;
	wire [15:0] nv_d = (done && srw_pend_q) ? pend_q : nv_q;
	wire [15:0] sr_view = {prot_q[15:9], wide_q, prot_q[7:2],
		wel_q, st_q == QFW_BUSY};

	// Unlisted opcodes match no decode term and fall through untouched
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			st_q       <= QFW_IDLE;
			tmr_q      <= 32'h0;
			wel_q      <= 1'b0;
			wide_q     <= 1'b0;
			pd_q       <= 1'b0;
			glock_q    <= 1'b0;
			arm_q      <= 1'b0;
			srw_pend_q <= 1'b0;
			pend_q     <= SR_RST;
			prot_q     <= SR_RST;
			nv_q       <= SR_RST;
			sr_q       <= SR_RST;
		end else if (ce) begin
			st_q       <= st_d;
			tmr_q      <= tmr_d;
			wel_q      <= wel_d;
			wide_q     <= wide_d;
			pd_q       <= pd_d;
			glock_q    <= glock_d;
			arm_q      <= arm_d;
			srw_pend_q <= srw_pend_d;
			pend_q     <= pend_d;
			prot_q     <= prot_d;
			nv_q       <= nv_d;
			sr_q       <= sr_view;
		end
	end

	// ---- Checks ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n_q);

	latch_set_a: assert property (
		ce && acc && solo && op == OP_WR_EN |=> wel_q)
		else $error("write enable did not set the latch");

	latch_clr_a: assert property (
		ce && acc && solo && op == OP_WR_DIS |=> !wel_q)
		else $error("write disable did not clear the latch");

	wide_set_a: assert property (
		ce && acc && solo && op == OP_WIDE_ON |=> ##1 sr_q[SB_WIDE])
		else $error("wide address flag not reported set");

	wide_clr_a: assert property (
		ce && acc && solo && op == OP_WIDE_OFF |=> ##1 !sr_q[SB_WIDE])
		else $error("wide address flag not reported clear");

	busy_hold_a: assert property (
		ce && start |=> (st_q == QFW_BUSY && wel_q) [*4])
		else $error("timed cycle ended early or latch dropped");

	busy_end_a: assert property (
		ce && done |=> st_q == QFW_IDLE && !wel_q)
		else $error("latch not cleared at end of timed cycle");

	refuse_a: assert property (
		ce && acc && !wel_q && (arr_op || (srw_ok && !arm_q))
		|=> st_q == QFW_IDLE && $stable(prot_q))
		else $error("command accepted without the write latch");

	hw_lock_a: assert property (
		ce && fe && idle && is_srw && hw_prot |=> $stable(prot_q)
		&& $stable(srw_pend_q))
		else $error("status write acted under hardware protection");

	arm_drop_a: assert property (
		ce && fe && op != OP_VOL_EN |=> !arm_q)
		else $error("volatile arm survived another command");

	vol_latch_a: assert property (
		ce && acc && solo && op == OP_VOL_EN && !wel_q |=> !wel_q && arm_q)
		else $error("volatile enable touched the write latch");

	abandon_a: assert property (
		ce && fe && idle && is_srw && n != NIB_OP + NIB_BYTE
		|=> $stable(prot_q) && $stable(srw_pend_q))
		else $error("status write ran with wrong length");

	pd_enter_a: assert property (
		ce && acc && solo && op == OP_PD_IN |=> pd_q)
		else $error("power-down entry not taken");

	pd_block_a: assert property (
		ce && fe && pd_q && op != OP_PD_OUT
		|=> $stable(wel_q) && $stable(prot_q))
		else $error("command acted during power-down");

	busy_view_a: assert property (
		ce && st_q == QFW_BUSY |=> sr_q[SB_BUSY])
		else $error("busy flag not reported during timed cycle");

	glock_set_a: assert property (
		ce && acc && solo && op == OP_GLOCK |=> glock_q)
		else $error("global lock not taken");

	vol_write_a: assert property (
		ce && vol_wr |=> st_q == QFW_IDLE && $stable(wel_q))
		else $error("volatile status write started a cycle");

	wide_addr_a: assert property (
		ce && wide_q |-> an == NIB_A4)
		else $error("wide mode did not select four address bytes");

endmodule

//--- bench/qfw_host.sv
// Host-side four-wire flash controller model
`timescale 1ns/1ps
module qfw_host (
	output logic            sclk,   // Link clock, still outside frames
	output logic            cs_n,   // Chip select, active low
	output logic      [3:0] io_in,  // Resolved data lines seen by device
	input  wire logic [3:0] io_out, // Device data out
	input  wire logic [3:0] io_oe   // Device drive enables
);
	logic [3:0] drv_val;
	logic       drv_en;

	// Released lines show device output when driven, else the inverse of the last value, not a stale copy
	assign io_in = drv_en ? drv_val : ((io_oe != 4'h0) ? io_out : ~drv_val);

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		drv_val = 4'h0;
		drv_en = 1'b0;
	end

	// One whole frame: ntx nibbles out, high nibble first, then nrx in
	task automatic xfer(input logic [63:0] tx, input int ntx, input int nrx,
		output logic [31:0] rx);
		rx = 32'h0;
		#7;
		cs_n = 1'b0;
		drv_en = 1'b1;
		for (int i = 0; i < ntx; i++) begin
			drv_val = tx[4*(ntx-1-i) +: 4];
			#24 sclk = 1'b1;
			#24 sclk = 1'b0;
		end
		drv_en = 1'b0;
		for (int i = 0; i < nrx; i++) begin
			#24 sclk = 1'b1;
			rx = {rx[27:0], io_out};
			#24 sclk = 1'b0;
		end
		// Select rises right after the last nibble, clock parked low
		#24 cs_n = 1'b1;
		#24;
	endtask
endmodule

//--- bench/qfw_write_ctrl_tb_top.sv
// Self-checking testbench for the flash write-control block
`timescale 1ns/1ps
module qfw_write_ctrl_tb_top
	import qfw_pkg::*;
;
	localparam int SWC = 200;
	logic        clk;
	logic        nrst;
	logic        ce;
	logic        wp_n;
	logic        sclk;
	logic        cs_n;
	logic        pd_q;
	logic        glock_q;
	logic [3:0]  io_in;
	logic [3:0]  io_out;
	logic [3:0]  io_oe;
	logic [15:0] sr_q;
	logic [31:0] rx;
	int          failures;
	int          num_checks;
	logic [7:0]  ops [16] = '{OP_PP4A, OP_PP4B, OP_PP4C, OP_SE3, OP_BE32,
		OP_BE64, OP_SE4, OP_BE32_4, OP_BE64_4, OP_CE_A, OP_CE_B,
		OP_OTP_PGM, OP_OTP_ERS, OP_PP3A, OP_CFG_VOL, OP_UPPER_WR};
	int          nib [16] = '{12, 12, 12, 8, 8, 8, 10, 10, 10, 2, 2, 10, 8,
		10, 10, 4};

	qfw_write_ctrl #(.SW_CYC(SWC)) DUT (.clk(clk), .nrst(nrst), .ce(ce),
		.sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
		.io_oe(io_oe), .wp_n(wp_n), .sr_q(sr_q), .pd_q(pd_q),
		.glock_q(glock_q));
	qfw_host host (.sclk(sclk), .cs_n(cs_n), .io_in(io_in),
		.io_out(io_out), .io_oe(io_oe));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic end_of_test();
		if (failures == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Frame, then let the decode settle into the status view
	task automatic cmd(input logic [63:0] tx, input int ntx,
		input int nrx = 0);
		host.xfer(tx, ntx, nrx, rx);
		repeat (8) @(negedge clk);
	endtask

	task automatic wait_idle();
		for (int i = 0; i < 300 && sr_q[0] !== 1'b0; i++)
			@(negedge clk);
	endtask

	task automatic t_latch();
		chk({pd_q, glock_q, sr_q}, 32'h0);
		cmd(OP_WR_EN, 2);
		chk(sr_q[1], 1'b1);
		cmd(OP_WR_DIS, 2);
		chk(sr_q[1], 1'b0);
		cmd({OP_SE3, 24'h0}, 8);
		chk(sr_q, 16'h0);
	endtask

	task automatic t_ops();
		for (int i = 0; i < 16; i++) begin
			cmd(OP_WR_EN, 2);
			cmd(64'(ops[i]) << (4 * (nib[i] - 2)), nib[i]);
			chk(sr_q[1:0], 2'b11);
			wait_idle();
			chk(sr_q[1:0], 2'b00);
		end
	endtask

	// Clock enable low must stretch the timed cycle
	task automatic t_freeze();
		cmd(OP_WR_EN, 2);
		cmd(OP_CE_A, 2);
		ce = 1'b0;
		repeat (250) @(negedge clk);
		chk(sr_q[1:0], 2'b11);
		ce = 1'b1;
		wait_idle();
		chk(sr_q[1:0], 2'b00);
	endtask

	task automatic t_wide();
		cmd(OP_WIDE_ON, 2);
		chk(sr_q[8], 1'b1);
		cmd(OP_SR2_RD, 2, 2);
		chk(rx[7:0], 8'h01);
		cmd(OP_WR_EN, 2);
		cmd({OP_SE3, 32'h0}, 10);
		chk(sr_q[1:0], 2'b11);
		wait_idle();
		cmd(OP_WIDE_OFF, 2);
		chk(sr_q[8], 1'b0);
	endtask

	task automatic t_status();
		cmd(OP_WR_EN, 2);
		cmd({OP_SR1_WR, 8'h7c}, 4);
		cmd(OP_SR1_RD, 2, 2);
		chk(rx[7:0], 8'h03);
		cmd(OP_ID_RD0, 2, 2);
		chk(rx[7:0], 8'h00);
		wait_idle();
		chk(sr_q[7:0], 8'h7c);
		cmd(OP_WR_EN, 2);
		cmd({OP_SR1_WR, 4'h0}, 3);
		chk(sr_q[7:0], 8'h7e);
		cmd({OP_SR1_WR, 12'h0}, 5);
		chk(sr_q[7:0], 8'h7e);
		cmd(OP_WR_DIS, 2);
	endtask

	task automatic t_volatile();
		cmd(OP_VOL_EN, 2);
		chk(sr_q[1], 1'b0);
		cmd({OP_SR1_WR, 8'h80}, 4);
		chk(sr_q[7:0], 8'h80);
		cmd(OP_VOL_EN, 2);
		cmd(OP_WIDE_OFF, 2);
		cmd({OP_SR1_WR, 8'h00}, 4);
		chk(sr_q[7:0], 8'h80);
		wp_n = 1'b0;
		cmd(OP_WR_EN, 2);
		cmd({OP_SR1_WR, 8'h00}, 4);
		chk(sr_q[7:0], 8'h82);
		wp_n = 1'b1;
		cmd(OP_WR_DIS, 2);
		cmd(OP_VOL_EN, 2);
		cmd({OP_SR1_WR, 8'h00}, 4);
		chk(sr_q[7:0], 8'h00);
	endtask

	task automatic t_misc();
		cmd(OP_ID_RD0, 2, 8);
		chk(rx, {MFR_CODE, DEV_CODE});
		chk(io_oe, 4'h0);
		cmd(OP_ID_RD1, 2, 8);
		chk(rx, {MFR_CODE, DEV_CODE});
		cmd(OP_GLOCK, 2);
		chk(glock_q, 1'b1);
		cmd({OP_LOCK_RD, 56'h0}, 16, 2);
		chk(rx[7:0], 8'hff);
		cmd(OP_GUNLOCK, 2);
		chk(glock_q, 1'b0);
		cmd({OP_OTP_RD, 48'h0}, 14, 2);
		chk(rx[7:0], 8'hff);
		cmd(OP_PD_IN, 2);
		chk(pd_q, 1'b1);
		cmd(OP_WR_EN, 2);
		chk(sr_q[1], 1'b0);
		cmd(OP_PD_OUT, 2);
		chk(pd_q, 1'b0);
		cmd(64'ha5, 2);
		chk({pd_q, glock_q, sr_q}, 32'h0);
	endtask

	initial begin
		failures = 0;
		num_checks = 0;
		nrst = 1'b0;
		ce = 1'b1;
		wp_n = 1'b1;
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		repeat (8) @(negedge clk);
		t_latch();
		t_ops();
		t_freeze();
		t_wide();
		t_status();
		t_volatile();
		t_misc();
		end_of_test();
	end

	// Whole run needs well under 100 us of traffic
	initial begin
		#300000;
		failures++;
		end_of_test();
	end
endmodule
